// ---- bench/panel_model.sv ----
`default_nettype none
module panel_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic stop_led,
  input  wire logic clr,
  output var  int   toggles,
  output var  int   half
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  int   cnt_q;
  // Lamp watcher: length of the last finished phase, in clocks
  always_ff @(posedge mclk) begin
    if (!rst_n || clr) begin
      toggles <= 0;
      cnt_q <= 0;
      prev_q <= stop_led;
    end else if (stop_led !== prev_q) begin
      toggles <= toggles + 1;
      half <= cnt_q + 1;
      cnt_q <= 0;
      prev_q <= stop_led;
    end else cnt_q <= cnt_q + 1;
  end
endmodule
`default_nettype wire

// ---- bench/stop_checker.sv ----
`default_nettype none
module stop_checker #(
  parameter int unsigned SLOW_HALF_CYC = 8,
  parameter int unsigned FAST_HALF_CYC = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic coord_test_mode,
  input wire logic overall_reset_done,
  input wire logic addressing_error,
  input wire logic user_exec_enable,
  input wire logic images_clear,
  input wire logic command_output_disable,
  input wire logic run_led,
  input wire logic stop_led,
  input wire logic output_disable_led,
  input wire logic addressing_error_led
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned lo_len_q;
  // A stalled divider would leave the stop lamp dark for good
  always_ff @(posedge mclk) begin
    if (!rst_n || stop_led || run_led) lo_len_q <= 0;
    else lo_len_q <= lo_len_q + 1;
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_exec_with_run: assert property (
    run_led == user_exec_enable) else $error("exec enable and run lamp differ");
  a_disable_in_stop: assert property (
    !user_exec_enable && !coord_test_mode && !$past(coord_test_mode) |-> command_output_disable)
    else $error("outputs not disabled in stop");
  a_enable_in_run: assert property (
    user_exec_enable |-> !command_output_disable) else $error("outputs disabled in run");
  a_lamp_in_stop: assert property (
    !run_led && !coord_test_mode && !$past(coord_test_mode) |-> output_disable_led)
    else $error("disable lamp dark in stop");
  a_test_hides_lamp: assert property (
    coord_test_mode [*3] |-> !output_disable_led) else $error("disable lamp lit in test");
  a_flash_low_bound: assert property (
    !run_led |-> lo_len_q <= SLOW_HALF_CYC + 1) else $error("stop lamp dark too long");
  a_adr_lamp_cause: assert property (
    $rose(addressing_error_led) |-> $past(addressing_error)) else $error("adr lamp no cause");
  a_err_lamp_stop: assert property (
    addressing_error_led |-> !run_led) else $error("error lamp lit in run");
  a_images_kept: assert property (
    images_clear |-> $past(overall_reset_done) || $past(overall_reset_done, 2))
    else $error("images cleared without overall reset");
  a_clear_single: assert property (
    images_clear |=> !images_clear) else $error("image clear longer than one cycle");
  a_bus_one_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest) else $error("bus wait too long");
endmodule
bind stop_mode_indicator stop_checker #(
  .SLOW_HALF_CYC(SLOW_HALF_CYC), .FAST_HALF_CYC(FAST_HALF_CYC)) chk (
  .mclk(mclk), .rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
  .coord_test_mode(coord_test_mode), .overall_reset_done(overall_reset_done),
  .addressing_error(addressing_error), .user_exec_enable(user_exec_enable),
  .images_clear(images_clear), .command_output_disable(command_output_disable),
  .run_led(run_led), .stop_led(stop_led), .output_disable_led(output_disable_led),
  .addressing_error_led(addressing_error_led));
`default_nettype wire

// ---- bench/tb_top.sv ----
`include "stop_regs.svh"
`default_nettype none
module tb_top;
  import stop_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW = 8;
  localparam int FAST = 2;
  localparam logic [13:0] MASK [16] = '{14'h0, 14'h1, 14'h8, 14'h10, 14'h2, 14'h20, 14'h40,
    14'h80, 14'h100, 14'h200, 14'h400, 14'h800, 14'h20, 14'h1000, 14'h2000, 14'h6};
  localparam logic [3:0] CAUSE [16] = '{4'h1, 4'h2, 4'h3, 4'h3, 4'h5, 4'h8, 4'h9, 4'hA,
    4'hA, 4'hA, 4'hA, 4'hC, 4'h8, 4'h6, 4'h7, 4'hB};
  logic        mclk = 1'h0, rst_n = 1'h0, read = 1'h0, write = 1'h0, sel = 1'h0;
  logic        tst = 1'h0, ovr_req = 1'h0, ovr_done = 1'h0, clr = 1'h0;
  logic [7:0]  address = 8'h0, lv = 8'h0;
  logic [13:0] st = 14'h0;
  logic [31:0] writedata = 32'h0, lc = 32'h0, q, readdata;
  logic        waitrequest, irq, uex, imc, cod, run_led, stop_led, odl, adl, tol, cyl;
  int          bad_count = 0, check_count = 0, toggles, half, seed = 32'h283C51BF;
  always #12.5 mclk = ~mclk;
  stop_mode_indicator #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) dut (
    .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .selector_run(sel), .remote_stop_command(st[0]), .end_test_command(st[1]),
    .end_test_this_cpu(st[2]), .battery_fault(st[3]), .io_supply_fault(st[4]),
    .stop_instruction(st[5]), .operator_error(st[6]), .program_error(st[7]),
    .addressing_error(st[8]), .timeout_error(st[9]), .cycle_time_error(st[10]),
    .init_error(st[11]), .overall_reset_request(ovr_req), .overall_reset_done(ovr_done),
    .coord_stop(st[12]), .coord_test_mode(tst), .other_cpu_fault_stop(st[13]),
    .interrupted_levels(lv), .level_causes(lc), .user_exec_enable(uex),
    .images_clear(imc), .command_output_disable(cod), .run_led(run_led),
    .stop_led(stop_led), .output_disable_led(odl), .addressing_error_led(adl),
    .timeout_error_led(tol), .cycle_time_error_led(cyl));
  panel_model pm (.mclk(mclk), .rst_n(rst_n), .stop_led(stop_led), .clr(clr),
    .toggles(toggles), .half(half));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest seen low; data taken then
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    @(posedge mclk);
    while (waitrequest !== 1'h0) @(posedge mclk);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  function automatic logic [1:0] exp_flash(input int k);
    if (k == 11 || k == 12) return FLASH_FAST;
    if (CAUSE[k] >= 4'h8) return FLASH_SLOW;
    return FLASH_STEADY;
  endfunction
  task run_case(input int k);
    int l;
    l = k % 8;
    bus(1'h1, `OFS_CTRL, {30'h0, 1'h1, k >= 13});
    bus(1'h1, `OFS_IRQ_CLEAR, 32'h7);
    bus(1'h1, `OFS_IRQ_ENABLE, {31'h0, k[0]});
    @(posedge mclk);
    sel <= 1'h1;
    lv <= 8'($random(seed));
    lc <= $random(seed);
    tick(2);
    chk({uex, cod, run_led}, 3'h5);
    @(posedge mclk);
    if (k == 0) sel <= 1'h0;
    st <= MASK[k];
    @(posedge mclk);
    st <= 14'h0;
    if (k == 12) ovr_req <= 1'h1;
    @(posedge mclk);
    ovr_req <= 1'h0;
    tick(2);
    chk({uex, cod, run_led, odl, imc, irq}, {5'hA, k[0]});
    chk({cyl, tol, adl}, {k == 10, k == 9, k == 8});
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk(q[7:1], {exp_flash(k), k == 11 || k == 12, CAUSE[k]});
    bus(1'h0, `OFS_INTERRUPT_STACK + 8'(4 * l), 32'h0);
    chk(q[4], lv[l]);
    if (lv[l]) chk(q[3:0], lc[4*l +: 4]);
    clr <= 1'h1;
    @(posedge mclk);
    clr <= 1'h0;
    tick(40);
    if (exp_flash(k) == FLASH_STEADY) chk({toggles[3:0], stop_led}, 5'h1);
    else chk(half, exp_flash(k) == FLASH_FAST ? FAST : SLOW);
    if (k >= 13) begin
      @(posedge mclk);
      tst <= 1'h1;
      tick(3);
      chk({cod, odl}, 2'h0);
      @(posedge mclk);
      tst <= 1'h0;
    end
    bus(1'h1, `OFS_IRQ_CLEAR, 32'h7);
    tick(1);
    chk(irq, 1'h0);
    @(posedge mclk);
    ovr_done <= 1'h1;
    sel <= 1'h0;
    @(posedge mclk);
    ovr_done <= 1'h0;
    @(negedge mclk);
    chk(imc, 1'h1);
    tick(3);
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk(q[10:1], {3'h0, FLASH_STEADY, 5'h4});
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    tick(0);
    chk({stop_led, cod, run_led}, 3'h6);
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk(q[10:0], 11'h1);
    bus(1'h0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 32; i++) run_case(i < 16 ? i : $unsigned($random(seed)) % 16);
    close_out();
  end
endmodule
`default_nettype wire

// ---- src/stop_mode_indicator.sv ----
// Behaviour
// R1: No user program instruction executes while stopped.
// R2: Counters, timers, flags and process images are kept on entering stop.
// R3: Command output disable is asserted while stopped, blocking digital outputs.
// R4: In multiprocessor mode, coordinator test mode keeps output disable deasserted.
// R5: Entering stop from run records each interrupted level with its cause.
// R6: Stopped: run LED off, stop LED steady or flashing, disable LED except test.
// R7: Single processor: selector, remote stop, fault, reset done, end test give steady.
// R8: Multiprocessor: coordinator selector at stop gives steady stop LED.
// R9: Stop caused by another CPU's fault gives steady stop LED here.
// R10: Error stops flash the stop LED slowly, about 0.5 Hz.
// R11: Multiprocessor: only the CPU whose error caused stop flashes slowly.
// R12: Stop instruction, operator error, programming or device error flash slowly.
// R13: Programming or device errors also light the matching error LED.
// R14: End test issued to this CPU flashes its stop LED slowly.
// R15: Pending overall reset request flashes the stop LED fast, about 2 Hz.
// R16: Initialization errors enter stop and flash the stop LED fast.
// R17: Flash rates divide the system clock; pending reset beats slow flashing.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`include "stop_regs.svh"
`default_nettype none
module stop_mode_indicator
  import stop_pkg::*;
#(
  parameter int unsigned SLOW_HALF_CYC = `SLOW_HALF_MS * `CLK_KHZ,
  parameter int unsigned FAST_HALF_CYC = `FAST_HALF_MS * `CLK_KHZ
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  input  wire logic        selector_run,
  input  wire logic        remote_stop_command,
  input  wire logic        end_test_command,
  input  wire logic        end_test_this_cpu,
  input  wire logic        battery_fault,
  input  wire logic        io_supply_fault,
  input  wire logic        stop_instruction,
  input  wire logic        operator_error,
  input  wire logic        program_error,
  input  wire logic        addressing_error,
  input  wire logic        timeout_error,
  input  wire logic        cycle_time_error,
  input  wire logic        init_error,
  input  wire logic        overall_reset_request,
  input  wire logic        overall_reset_done,
  input  wire logic        coord_stop,
  input  wire logic        coord_test_mode,
  input  wire logic        other_cpu_fault_stop,
  input  wire logic [7:0]  interrupted_levels,
  input  wire logic [31:0] level_causes,
  output logic             user_exec_enable,
  output logic             images_clear,
  output logic             command_output_disable,
  output logic             run_led,
  output logic             stop_led,
  output logic             output_disable_led,
  output logic             addressing_error_led,
  output logic             timeout_error_led,
  output logic             cycle_time_error_led
);

  localparam int unsigned LEVELS = 8;

  mode_t       mode_q;
  cause_t      cause_q;
  cause_t      stop_cause;
  logic        stop_req;
  logic        start_ok;
  logic        sel_q;
  logic        ovr_req_q;
  logic [2:0]  err_led_q;
  logic [1:0]  ctrl_q;
  logic [2:0]  irq_status_q;
  logic [2:0]  irq_enable_q;
  logic [2:0]  irq_event;
  logic        ack_q;
  logic        wr_en;
  logic        mp_mode;
  logic        stop_now;
  logic        go_run;
  logic        fault_any;
  logic        err_any;
  logic [4:0]  interrupt_stack_q [LEVELS];
  logic [25:0] slow_cnt_q;
  logic [25:0] fast_cnt_q;
  logic        slow_ph_q;
  logic        fast_ph_q;
  flash_t      flash_mode;
  logic        stop_led_d;
  logic        interrupt_stack_hit;
  logic [31:0] status_word;

  assign mp_mode   = ctrl_q[`CTRL_MP_BIT];
  assign fault_any = battery_fault | io_supply_fault;
  assign err_any   = program_error | addressing_error | timeout_error | cycle_time_error;

  // Stop causes while running, highest priority first
  always_comb begin
    stop_req   = 1'b1;
    stop_cause = CAUSE_SELECTOR;
    if (fault_any) begin
      stop_cause = CAUSE_DEVICE_FAULT; // R7
    end else if (err_any) begin
      stop_cause = CAUSE_PROG_ERROR; // R12
    end else if (operator_error) begin
      stop_cause = CAUSE_OPERATOR; // R12
    end else if (stop_instruction) begin
      stop_cause = CAUSE_STOP_INSTR; // R12
    end else if (end_test_command) begin
      stop_cause = (mp_mode && end_test_this_cpu) ? CAUSE_END_TEST_SELF // R14
                                                  : CAUSE_END_TEST; // R7
    end else if (remote_stop_command) begin
      stop_cause = CAUSE_REMOTE_STOP; // R7
    end else if (mp_mode && other_cpu_fault_stop) begin
      stop_cause = CAUSE_OTHER_CPU; // R9
    end else if (mp_mode && coord_stop) begin
      stop_cause = CAUSE_COORD_STOP; // R8
    end else if (sel_q && !selector_run) begin
      stop_cause = CAUSE_SELECTOR; // R7
    end else begin
      stop_req = 1'b0;
    end
  end

  // Restart needs a fresh selector RUN edge and nothing pending
  assign start_ok = selector_run && !sel_q && ctrl_q[`CTRL_START_BIT] && !ovr_req_q &&
                    !init_error && !fault_any && !(mp_mode && coord_stop);

  // Outputs react to stop_now in the same edge that leaves run
  assign stop_now = (mode_q == ST_RUN) && (stop_req || init_error);
  assign go_run   = (mode_q == ST_STOP) && start_ok;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= selector_run;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q  <= ST_STOP;
      cause_q <= CAUSE_POWER_UP;
    end else begin
      case (mode_q)
        ST_RUN: begin
          if (init_error) begin
            mode_q  <= ST_STOP; // R16
            cause_q <= CAUSE_INIT_ERROR;
          end else if (stop_req) begin
            mode_q  <= ST_STOP;
            cause_q <= stop_cause;
          end
        end
        ST_STOP: begin
          if (init_error) begin
            cause_q <= CAUSE_INIT_ERROR; // R16
          end else if (overall_reset_done) begin
            cause_q <= CAUSE_OVR_DONE; // R7
          end else if (go_run) begin
            mode_q <= ST_RUN;
          end
        end
        default: begin
          mode_q <= ST_STOP;
        end
      endcase
    end
  end

  // Error LEDs name the detected cause of a programming or device error
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_led_q <= 3'h0;
    end else if (stop_now && !init_error && !fault_any && err_any) begin
      err_led_q <= {cycle_time_error, timeout_error, addressing_error}; // R13
    end else if (go_run || overall_reset_done) begin
      err_led_q <= 3'h0;
    end
  end

  // Pending overall reset: request wins over a simultaneous completion
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovr_req_q <= 1'b0;
    end else if (overall_reset_request || init_error) begin
      ovr_req_q <= 1'b1; // R16
    end else if (overall_reset_done && mode_q == ST_STOP) begin
      ovr_req_q <= 1'b0;
    end
  end

  // Only an overall reset wipes data; entering stop leaves it intact
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      images_clear <= 1'b0;
    end else begin
      images_clear <= overall_reset_done && mode_q == ST_STOP; // R2
    end
  end

  // One record per level, flagged if interrupted, captured only when leaving run
  for (genvar i = 0; i < LEVELS; i++) begin : g_interrupt_stack
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        interrupt_stack_q[i] <= 5'h00;
      end else if (stop_now) begin
        interrupt_stack_q[i] <= {interrupted_levels[i], level_causes[4*i +: 4]}; // R5
      end else if (overall_reset_done && mode_q == ST_STOP) begin
        interrupt_stack_q[i] <= 5'h00;
      end
    end
  end

  // Flash cadences divided from mclk
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      slow_cnt_q <= 26'h0000000;
      slow_ph_q  <= 1'b0;
    end else if (slow_cnt_q == 26'(SLOW_HALF_CYC - 1)) begin
      slow_cnt_q <= 26'h0000000; // R17
      slow_ph_q  <= ~slow_ph_q; // R10
    end else begin
      slow_cnt_q <= slow_cnt_q + 26'h0000001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fast_cnt_q <= 26'h0000000;
      fast_ph_q  <= 1'b0;
    end else if (fast_cnt_q == 26'(FAST_HALF_CYC - 1)) begin
      fast_cnt_q <= 26'h0000000; // R17
      fast_ph_q  <= ~fast_ph_q; // R15
    end else begin
      fast_cnt_q <= fast_cnt_q + 26'h0000001;
    end
  end

  // Pending reset outranks any error flashing
  always_comb begin
    if (ovr_req_q || cause_q == CAUSE_INIT_ERROR) begin
      flash_mode = FLASH_FAST; // R15 R16 R17
    end else begin
      case (cause_q)
        CAUSE_STOP_INSTR,
        CAUSE_OPERATOR,
        CAUSE_PROG_ERROR,
        CAUSE_END_TEST_SELF: flash_mode = FLASH_SLOW; // R10 R11 R12 R14
        default:             flash_mode = FLASH_STEADY; // R7 R8 R9
      endcase
    end
  end

  always_comb begin
    case (flash_mode)
      FLASH_FAST: stop_led_d = fast_ph_q;
      FLASH_SLOW: stop_led_d = slow_ph_q;
      default:    stop_led_d = 1'b1;
    endcase
  end

  // Status word assembled apart from the bus decode
  always_comb begin
    status_word                       = 32'h00000000;
    status_word[`STAT_STOP_BIT]       = mode_q == ST_STOP;
    status_word[`STAT_CAUSE_LSB +: 4] = cause_q;
    status_word[`STAT_OVR_BIT]        = ovr_req_q;
    status_word[`STAT_FLASH_LSB +: 2] = flash_mode;
    status_word[`STAT_ERR_LSB +: 3]   = err_led_q;
  end

  // Front panel lamps; run lamp drops together with execution
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_led            <= 1'b0;
      stop_led           <= 1'b1;
      output_disable_led <= 1'b1;
    end else begin
      run_led            <= mode_q == ST_RUN && !stop_now; // R6
      stop_led           <= mode_q == ST_STOP && stop_led_d; // R6
      output_disable_led <= (mode_q == ST_STOP || stop_now) && !coord_test_mode; // R6
    end
  end

  // Outputs blocked in the very edge that execution stops, no gap
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      command_output_disable <= 1'b1;
      user_exec_enable       <= 1'b0;
    end else begin
      command_output_disable <= (mode_q == ST_STOP || stop_now) &&
                                !(mp_mode && coord_test_mode); // R3 R4
      user_exec_enable       <= mode_q == ST_RUN && !stop_now; // R1
    end
  end

  assign addressing_error_led = err_led_q[0];
  assign timeout_error_led    = err_led_q[1];
  assign cycle_time_error_led = err_led_q[2];

  // Bus slave: one wait cycle per access
  assign waitrequest = (read || write) && !ack_q;
  assign wr_en       = write && ack_q;
  assign interrupt_stack_hit  = address[7:5] == 3'(`OFS_INTERRUPT_STACK >> 5) && address[1:0] == 2'h0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if (read && !ack_q) begin
      readdata <= 32'h00000000;
      if (address == `OFS_CTRL) begin
        readdata[1:0] <= ctrl_q;
      end else if (address == `OFS_STATUS) begin
        readdata <= status_word;
      end else if (address == `OFS_IRQ_STATUS) begin
        readdata[2:0] <= irq_status_q;
      end else if (address == `OFS_IRQ_ENABLE) begin
        readdata[2:0] <= irq_enable_q;
      end else if (interrupt_stack_hit) begin
        readdata[4:0] <= interrupt_stack_q[address[4:2]];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_en && address == `OFS_CTRL) begin
      ctrl_q <= writedata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_enable_q <= `IRQ_RESET;
    end else if (wr_en && address == `OFS_IRQ_ENABLE) begin
      irq_enable_q <= writedata[2:0];
    end
  end

  assign irq_event[`IRQ_STOP_BIT] = stop_now;
  assign irq_event[`IRQ_RUN_BIT]  = go_run && !init_error && !overall_reset_done;
  assign irq_event[`IRQ_OVR_BIT]  = (overall_reset_request || init_error) && !ovr_req_q;

  // A new event beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_status_q <= `IRQ_RESET;
    end else if (wr_en && address == `OFS_IRQ_CLEAR) begin
      irq_status_q <= (irq_status_q & ~writedata[2:0]) | irq_event;
    end else begin
      irq_status_q <= irq_status_q | irq_event;
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

endmodule
`default_nettype wire

// ---- src/stop_pkg.sv ----
`default_nettype none
package stop_pkg;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_STOP = 2'b10
  } mode_t;

  typedef enum logic [3:0] {
    CAUSE_POWER_UP      = 4'h0,
    CAUSE_SELECTOR      = 4'h1,
    CAUSE_REMOTE_STOP   = 4'h2,
    CAUSE_DEVICE_FAULT  = 4'h3,
    CAUSE_OVR_DONE      = 4'h4,
    CAUSE_END_TEST      = 4'h5,
    CAUSE_COORD_STOP    = 4'h6,
    CAUSE_OTHER_CPU     = 4'h7,
    CAUSE_STOP_INSTR    = 4'h8,
    CAUSE_OPERATOR      = 4'h9,
    CAUSE_PROG_ERROR    = 4'hA,
    CAUSE_END_TEST_SELF = 4'hB,
    CAUSE_INIT_ERROR    = 4'hC
  } cause_t;

  typedef enum logic [1:0] {
    FLASH_STEADY = 2'h0,
    FLASH_SLOW   = 2'h1,
    FLASH_FAST   = 2'h2
  } flash_t;
endpackage
`default_nettype wire

// ---- src/stop_regs.svh ----
`ifndef STOP_REGS_SVH
`define STOP_REGS_SVH
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STATUS  8'h08
`define OFS_IRQ_CLEAR   8'h0C
`define OFS_IRQ_ENABLE  8'h10
`define OFS_INTERRUPT_STACK      8'h40
// CTRL fields
`define CTRL_MP_BIT     0
`define CTRL_START_BIT  1
`define CTRL_RESET      2'h2
// STATUS fields
`define STAT_STOP_BIT   0
`define STAT_CAUSE_LSB  1
`define STAT_OVR_BIT    5
`define STAT_FLASH_LSB  6
`define STAT_ERR_LSB    8
// IRQ fields
`define IRQ_STOP_BIT    0
`define IRQ_RUN_BIT     1
`define IRQ_OVR_BIT     2
`define IRQ_RESET       3'h0
// Interrupt stack entry fields
`define ISTK_CAUSE_LSB  0
`define ISTK_VALID_BIT  4
// Flash timing
`define CLK_KHZ         40000
`define SLOW_HALF_MS    1000
`define FAST_HALF_MS    250
`endif
